// ===== inc/fault_status_pkg.sv
// constants for the regulation fault event/mask logic
// assumes a single 20 MHz system clock and one command decoder upstream
package fault_status_pkg;
// Overview of operation
// [R1] each event bit latches on its condition and holds until cleared.
// [R2] reading the event register returns its contents then clears it.
// [R3] the clear-status command clears event bits but not the mask.
// [R4] instrument reset or device clear leaves latched event bits alone.
// [R5] an event read returns the binary-weighted sum of the set bits.
// [R6] the summary is the OR of event bits whose mask bit is set.
// [R7] the mask is readable and writable and reading never alters it.
// [R8] the host writes the mask with ones at the positions to enable.
// [R9] bit 0 (weight 1) sets when the supply enters constant current.
// [R10] bit 1 (weight 2) sets when the supply enters constant voltage.
// [R11] even a momentary constant-current entry sets bit 0; cond_sync here drops pulses shorter than two clocks.
// [R12] bit 4 (weight 16) sets on a fan fault or overtemperature.
// [R13] bit 9 (weight 512) sets when the overvoltage guard trips.
// [R14] writing zero to the mask clears it and disables the summary.
// [R15] unused bit positions read as zero and never latch.
// [R16] conditions are sampled every clock and a set beats a clear.
// [R17] the summary drives bit 3 (weight 8) of the status byte.

   localparam int          REG_W          = 16;
   localparam int          BIT_VOLT_UNREG = 0;
   localparam int          BIT_CURR_UNREG = 1;
   localparam int          BIT_OVERTEMP   = 4;
   localparam int          BIT_OVP_TRIP   = 9;
   localparam logic [15:0] IMPL_MASK      = 16'h0213;
   localparam logic [15:0] EVENT_RESET    = 16'h0000;
   localparam logic [15:0] MASK_RESET     = 16'h0000;
   localparam int          SB_W           = 8;
   localparam int          SB_FAULT_BIT   = 3;
   localparam int          SYNC_STAGES    = 3;
endpackage : fault_status_pkg

// ===== core/cond_sync.sv
// three-stage synchroniser for asynchronous condition pins
// assumes inputs from analog comparators outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cond_sync
   import fault_status_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic async_i,
   output var  logic level_o
);
   logic [SYNC_STAGES-1:0] stage;

   // ***********************************************************
   // shift chain
   // ***********************************************************
   // first stage is read only by the second
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         stage <= '0;
      else
         stage <= {stage[SYNC_STAGES-2:0], async_i};
   end

   // change accepted once stages two and three agree
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         level_o <= 1'b0;
      else if (stage[1] == stage[2])
         level_o <= stage[2];
   end
endmodule : cond_sync
`default_nettype wire

// ===== core/regulation_fault_status.sv
// regulation fault event register, enable mask and summary bit
// assumes a command decoder gives one-cycle strobes for each command
`timescale 1ns/1ps
`default_nettype none
module regulation_fault_status
   import fault_status_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              const_current_i,
   input  wire logic              const_voltage_i,
   input  wire logic              fan_fault_i,
   input  wire logic              overvoltage_guard_i,
   input  wire logic              fault_event_read_i,
   input  wire logic              fault_event_read_short_i,
   input  wire logic              clear_status_command_i,
   input  wire logic              instrument_reset_i,
   input  wire logic              device_clear_i,
   input  wire logic              fault_mask_write_i,
   input  wire logic [REG_W-1:0]  mask_wdata_i,
   input  wire logic              fault_mask_read_i,
   output var  logic [REG_W-1:0]  rdata_o,
   output var  logic              rvalid_o,
   output var  logic              regulation_fault_summary_o,
   output var  logic [SB_W-1:0]   status_byte_bits_o
);
   logic [REG_W-1:0] regulation_fault_event;
   logic [REG_W-1:0] fault_mask;
   logic [REG_W-1:0] cond_now;
   logic [REG_W-1:0] next_event;
   logic [3:0]       raw_cond;
   logic [3:0]       sync_cond;
   logic             ev_read;

   // ***********************************************************
   // condition synchronisers
   // ***********************************************************
   assign raw_cond = {overvoltage_guard_i, fan_fault_i,
                      const_voltage_i, const_current_i};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         cond_sync u_sync (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .async_i   (raw_cond[gi]),
            .level_o   (sync_cond[gi])
         );
      end
   endgenerate

   // map conditions onto their bit positions, others stay zero
   always_comb
   begin
      cond_now                 = '0;                   // R15
      cond_now[BIT_VOLT_UNREG] = sync_cond[0];         // R9 R11
      cond_now[BIT_CURR_UNREG] = sync_cond[1];         // R10
      cond_now[BIT_OVERTEMP]   = sync_cond[2];         // R12
      cond_now[BIT_OVP_TRIP]   = sync_cond[3];         // R13
   end

   assign ev_read = fault_event_read_i | fault_event_read_short_i;

   // ***********************************************************
   // event register
   // ***********************************************************
   // clear first, then or in live conditions so a set wins
   // reset and device-clear strobes are deliberately not used here
   always_comb
   begin
      next_event = regulation_fault_event;
      if (ev_read || clear_status_command_i)             // R2 R3
         next_event = '0;
      next_event = (next_event | cond_now) & IMPL_MASK;  // R1 R16 R15
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         regulation_fault_event <= EVENT_RESET;
      else
         regulation_fault_event <= next_event;            // R1 R4
   end

   // ***********************************************************
   // enable mask
   // ***********************************************************
   // clear-status leaves the mask alone; a zero write empties it
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         fault_mask <= MASK_RESET;
      else if (fault_mask_write_i)
         fault_mask <= mask_wdata_i;                    // R7 R14 R3
   end

   // ***********************************************************
   // read data and summary
   // ***********************************************************
   // event read takes precedence if both strobes arrive together
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_o  <= '0;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= ev_read | fault_mask_read_i;
         if (ev_read)
            rdata_o <= regulation_fault_event;          // R2 R5
         else if (fault_mask_read_i)
            rdata_o <= fault_mask;                      // R7
      end
   end

   // summary is combinational so it tracks the event bits directly
   assign regulation_fault_summary_o =
      |(regulation_fault_event & fault_mask);           // R6

   // only bit 3 carries the summary, the rest belong to other groups
   always_comb
   begin
      status_byte_bits_o = '0;
      status_byte_bits_o[SB_FAULT_BIT] = regulation_fault_summary_o; // R17
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_read_clears: assert property ( // R2
      (ev_read && !(|cond_now)) |=> regulation_fault_event == '0)
      else $error("event read did not clear the register");

   a_read_value: assert property ( // R5
      ev_read |=> (rvalid_o && rdata_o == $past(regulation_fault_event)))
      else $error("event read returned wrong value");

   a_cls_keeps_mask: assert property ( // R3
      (clear_status_command_i && !fault_mask_write_i)
      |=> $stable(fault_mask))
      else $error("clear status changed the mask");

   a_latch_holds: assert property ( // R1
      (!ev_read && !clear_status_command_i)
      |=> ((regulation_fault_event & $past(regulation_fault_event))
           == $past(regulation_fault_event)))
      else $error("latched event bit was lost");

   a_rst_keeps_event: assert property ( // R4
      ((instrument_reset_i || device_clear_i) && !ev_read
       && !clear_status_command_i)
      |=> ((regulation_fault_event & $past(regulation_fault_event))
           == $past(regulation_fault_event)))
      else $error("reset or device clear dropped an event");

   a_set_wins: assert property ( // R16
      (cond_now[BIT_VOLT_UNREG] && clear_status_command_i)
      |=> regulation_fault_event[BIT_VOLT_UNREG])
      else $error("event lost at clear");

   a_unused_zero: assert property ( // R15
      (regulation_fault_event & ~IMPL_MASK) == '0)
      else $error("unused event bit set");

   a_summary_or: assert property ( // R6
      regulation_fault_summary_o ==
      |(regulation_fault_event & fault_mask))
      else $error("summary mismatch");

   a_zero_mask: assert property ( // R14
      (fault_mask_write_i && mask_wdata_i == '0)
      ##1 !fault_mask_write_i |-> !regulation_fault_summary_o)
      else $error("zero mask left summary active");

   a_ovp_latch: assert property ( // R13
      cond_now[BIT_OVP_TRIP] |=> regulation_fault_event[BIT_OVP_TRIP])
      else $error("overvoltage trip not latched");

   a_sb_bit: assert property ( // R17
      status_byte_bits_o == {4'h0, regulation_fault_summary_o, 3'h0})
      else $error("status byte bit wrong");

   a_mask_read_keeps: assert property ( // R7
      (fault_mask_read_i && !fault_mask_write_i)
      |=> $stable(fault_mask))
      else $error("mask read altered the mask");

   a_mask_rd_value: assert property ( // R7
      (fault_mask_read_i && !ev_read)
      |=> (rvalid_o && rdata_o == $past(fault_mask)))
      else $error("mask read returned wrong value");

   a_mask_write: assert property ( // R14
      fault_mask_write_i |=> fault_mask == $past(mask_wdata_i))
      else $error("mask write did not land");

   a_cc_latch: assert property ( // R9
      cond_now[BIT_VOLT_UNREG] |=> regulation_fault_event[BIT_VOLT_UNREG])
      else $error("constant current entry not latched");

   a_cv_latch: assert property ( // R10
      cond_now[BIT_CURR_UNREG] |=> regulation_fault_event[BIT_CURR_UNREG])
      else $error("constant voltage entry not latched");

   a_fan_latch: assert property ( // R12
      cond_now[BIT_OVERTEMP] |=> regulation_fault_event[BIT_OVERTEMP])
      else $error("fan fault not latched");

   a_rvalid_pulse: assert property ( // R5
      !(ev_read || fault_mask_read_i) |=> !rvalid_o)
      else $error("read valid without a read strobe");

   c_event_read: cover property (ev_read && regulation_fault_event != '0);
   c_summary: cover property ($rose(regulation_fault_summary_o));
   c_set_clear: cover property (clear_status_command_i && |cond_now);
   c_mask_read: cover property (fault_mask_read_i ##1 rvalid_o);
endmodule : regulation_fault_status
`default_nettype wire

// ===== sim/tb_regulation_fault_status.sv
// self-checking bench for the regulation fault event register and mask
// assumes conditions need about five edges to reach the event register
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
   begin \
      samples_checked++; \
      if ((a) !== (e)) \
      begin \
         $display("CHECK FAILED %s exp %h got %h", n, e, a); \
         miscompares++; \
      end \
   end
module tb_regulation_fault_status
   import fault_status_pkg::*;
;
   logic             clk_sys_i;
   logic             rst_n_i;
   logic [3:0]       cond;
   logic [4:0]       cmd_s;
   logic             ev_rd;
   logic             ev_rd_s;
   logic             mrd;
   logic             mwr;
   logic [REG_W-1:0] wdata;
   logic [REG_W-1:0] rdata;
   logic [REG_W-1:0] d;
   logic             rvalid;
   logic             summ;
   logic [SB_W-1:0]  sb;
   int               miscompares;
   int               samples_checked;

   regulation_fault_status regulation_fault_status_i (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .const_current_i(cond[0]), .const_voltage_i(cond[1]),
      .fan_fault_i(cond[2]), .overvoltage_guard_i(cond[3]),
      .fault_event_read_i(ev_rd), .fault_event_read_short_i(ev_rd_s),
      .clear_status_command_i(cmd_s[0]), .instrument_reset_i(cmd_s[1]),
      .device_clear_i(cmd_s[2]), .fault_mask_write_i(mwr),
      .mask_wdata_i(wdata), .fault_mask_read_i(mrd), .rdata_o(rdata),
      .rvalid_o(rvalid), .regulation_fault_summary_o(summ),
      .status_byte_bits_o(sb));

   // ****************************************
   // access tasks
   // ****************************************
   // k: 0 event read, 1 short event read, 2 mask read
   task rd(input int k, output logic [REG_W-1:0] v);
      @(posedge clk_sys_i);
      ev_rd <= (k == 0);
      ev_rd_s <= (k == 1);
      mrd <= (k == 2);
      @(posedge clk_sys_i);
      {ev_rd, ev_rd_s, mrd} <= 3'h0;
      #1;
      `CHK("rvalid", 1'b1, rvalid)
      v = rdata;
   endtask : rd
   // k: 0 clear status, 1 instrument reset, 2 device clear, 3 mask write
   task cmd(input int k, input logic [REG_W-1:0] v);
      @(posedge clk_sys_i);
      cmd_s <= 5'h01 << k;
      mwr <= (k == 3);
      wdata <= v;
      @(posedge clk_sys_i);
      cmd_s <= 5'h00;
      mwr <= 1'b0;
      #1;
   endtask : cmd
   // pulse two samples wide so the glitch filter accepts it
   task hit(input logic [3:0] v);
      @(posedge clk_sys_i);
      cond <= v;
      repeat (2) @(posedge clk_sys_i);
      cond <= 4'h0;
      repeat (6) @(posedge clk_sys_i);
      #1;
   endtask : hit
   task final_report;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // ****************************************
   // clock, reset and watchdog
   // ****************************************
   initial
   begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // whole run is well under 300 cycles
   initial
   begin
      repeat (3000) @(posedge clk_sys_i);
      miscompares++;
      final_report();
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial
   begin
      {rst_n_i, cond, cmd_s, ev_rd, ev_rd_s, mrd, mwr} = '0;
      wdata = '0;
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1;
      `CHK("summary reset", 1'b0, summ)
      rd(2, d); `CHK("mask reset", 16'h0000, d)
      cmd(3, 16'hFFFF);
      rd(2, d); `CHK("mask rd", 16'hFFFF, d)
      rd(2, d); `CHK("mask rd2", 16'hFFFF, d)
      hit(4'h1);
      `CHK("summary cc", 1'b1, summ)
      rd(0, d); `CHK("blip cc", 16'h0001, d)
      rd(0, d); `CHK("auto clear", 16'h0000, d)
      hit(4'hF);
      `CHK("status byte", 8'h08, sb)
      cmd(1, '0);
      cmd(2, '0);
      `CHK("sum held", 1'b1, summ)
      rd(1, d); `CHK("all bits", 16'h0213, d)
      // clear-status must drop events but keep the mask
      hit(4'h4);
      cmd(0, '0);
      `CHK("sum cls", 1'b0, summ)
      `CHK("sb cls", 8'h00, sb)
      rd(2, d); `CHK("mask cls", 16'hFFFF, d)
      rd(0, d); `CHK("ev cls", 16'h0000, d)
      // selective mask: only the fan bit counts
      cmd(3, 16'h0010);
      hit(4'h1);
      `CHK("sum masked", 1'b0, summ)
      hit(4'h4);
      `CHK("sum fan", 1'b1, summ)
      cmd(3, 16'h0000);
      `CHK("sum mask0", 1'b0, summ)
      rd(2, d); `CHK("mask0", 16'h0000, d)
      rd(0, d); `CHK("ev two", 16'h0011, d)
      // held condition survives read and clear
      @(posedge clk_sys_i);
      cond <= 4'h2;
      repeat (6) @(posedge clk_sys_i);
      rd(0, d); `CHK("cv held", 16'h0002, d)
      rd(1, d); `CHK("cv relatch", 16'h0002, d)
      cmd(0, '0);
      @(posedge clk_sys_i);
      cond <= 4'h8;
      repeat (6) @(posedge clk_sys_i);
      cond <= 4'h0;
      rd(0, d); `CHK("cls vs set", 16'h0202, d)
      final_report();
   end
endmodule : tb_regulation_fault_status
`undef CHK
`default_nettype wire
